//--- design/dma_pair_defs.svh
`ifndef DMA_PAIR_DEFS_SVH
`define DMA_PAIR_DEFS_SVH
// register byte offsets
`define OFS_RX_POINTER      12'h100
`define OFS_RX_COUNTER      12'h104
`define OFS_TX_POINTER      12'h108
`define OFS_TX_COUNTER      12'h10c
`define OFS_RX_NEXT_POINTER 12'h110
`define OFS_RX_NEXT_COUNTER 12'h114
`define OFS_TX_NEXT_POINTER 12'h118
`define OFS_TX_NEXT_COUNTER 12'h11c
`define OFS_CONTROL         12'h120
`define OFS_STATUS          12'h124
`define OFS_IRQ_STATUS      12'h128
`define OFS_IRQ_MASK        12'h12c
// control and status bit positions
`define BIT_RX_ENABLE       0
`define BIT_RX_DISABLE      1
`define BIT_TX_ENABLE       8
`define BIT_TX_DISABLE      9
// interrupt status bit positions
`define BIT_IRQ_RX_END      0
`define BIT_IRQ_RX_FULL     1
`define BIT_IRQ_TX_END      2
`define BIT_IRQ_TX_EMPTY    3
`define IRQ_BITS            4
`define COUNT_BITS          16
`define ADDR_BITS           12
`define ZERO_WORD           32'h0000_0000
`define ZERO_COUNT          16'h0000
`define ONE_COUNT           16'h0001
// transfer sizes
`define SIZE_BYTE           2'h0
`define SIZE_HALF           2'h1
`define SIZE_WORD           2'h2
`define STEP_BYTE           32'h0000_0001
`define STEP_HALF           32'h0000_0002
`define STEP_WORD           32'h0000_0004
`endif

//--- design/dma_pair_pkg.sv
package dma_pair_pkg;
  typedef struct packed
  {
    logic [31:0] pointer;
    logic [15:0] count;
    logic [31:0] next_pointer;
    logic [15:0] next_count;
  } channel_state_type;

  typedef struct packed
  {
    logic        request;
    logic [1:0]  size;
  } transfer_req_type;
endpackage

//--- design/peripheral_dma_channel_pair.sv
// What this block does
// - software read/write transmit memory pointer
// - transmit counter; zero stops transmit transfers
// - receive next pointer register
// - receive next counter, sixteen bits
// - transmit next pointer register
// - transmit next counter, sixteen bits
// - receive enable write, unless disable also set
// - receive disable write stops receive requests
// - transmit enable write starts transmit requests
// - transmit disable write stops transmit requests
// - status bit 0 shows receive enabled
// - status bit 8 shows transmit enabled
// - each transfer steps pointer, decrements counter
// - counter zero reloads from a nonzero next counter, clears next counter
// - end flag, and both-empty flag
// - counter writes clear that end flag
`timescale 1ns/1ps
`include "dma_pair_defs.svh"

module peripheral_dma_channel_pair
#(
  // fixed by the register layout; other values are refused below
  parameter int ADDR_WIDTH  = `ADDR_BITS,
  parameter int COUNT_WIDTH = `COUNT_BITS
)
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // peripheral ready strobes, same clock domain
  input  wire logic        rx_ready,
  input  wire logic        tx_ready,
  input  wire logic [1:0]  transfer_size,
  // transfer done from system bus, one pulse each
  input  wire logic        rx_done,
  input  wire logic        tx_done,
  // transfer requests toward system bus
  output logic             rx_transfer_req,
  output logic             tx_transfer_req,
  output logic      [31:0] rx_address,
  output logic      [31:0] tx_address,
  // flags to peripheral status and interrupt
  output logic             rx_buffer_end_flag,
  output logic             tx_buffer_end_flag,
  output logic             rx_buffers_full_flag,
  output logic             tx_buffers_empty_flag,
  output logic             irq
);

  // the channel struct and the address decode are built for one layout only
  generate
    if (ADDR_WIDTH != `ADDR_BITS || COUNT_WIDTH != `COUNT_BITS)
    begin : g_bad_params
      $error("unsupported address or counter width");
    end
  endgenerate

  dma_pair_pkg::channel_state_type rx;
  dma_pair_pkg::channel_state_type tx;
  logic                      rx_request_enable;
  logic                      tx_request_enable;
  logic [`IRQ_BITS-1:0]      irq_status;
  logic [`IRQ_BITS-1:0]      irq_mask;
  dma_pair_pkg::transfer_req_type rx_req;
  dma_pair_pkg::transfer_req_type tx_req;

  // apb decode; zero wait states
  wire        access      = psel & penable;
  wire        wr          = access & pwrite;
  wire        rd_phase    = psel & ~penable & ~pwrite;
  wire        hit_rp      = paddr == `OFS_RX_POINTER;
  wire        hit_rc      = paddr == `OFS_RX_COUNTER;
  wire        hit_tp      = paddr == `OFS_TX_POINTER;
  wire        hit_tc      = paddr == `OFS_TX_COUNTER;
  wire        hit_rnp     = paddr == `OFS_RX_NEXT_POINTER;
  wire        hit_rnc     = paddr == `OFS_RX_NEXT_COUNTER;
  wire        hit_tnp     = paddr == `OFS_TX_NEXT_POINTER;
  wire        hit_tnc     = paddr == `OFS_TX_NEXT_COUNTER;
  wire        hit_ctl     = paddr == `OFS_CONTROL;
  wire        hit_sts     = paddr == `OFS_STATUS;
  wire        hit_ist     = paddr == `OFS_IRQ_STATUS;
  wire        hit_imk     = paddr == `OFS_IRQ_MASK;
  wire        hit_any     = hit_rp | hit_rc | hit_tp | hit_tc | hit_rnp | hit_rnc | hit_tnp | hit_tnc
                            | hit_ctl | hit_sts | hit_ist | hit_imk;
  // write-only control and read-only status refuse the wrong direction
  wire        bad_access  = ~hit_any | (hit_ctl & ~pwrite) | (hit_sts & pwrite);

  wire [15:0] wcount      = pwdata[COUNT_WIDTH-1:0];

  // step size latched with the request, so a size change mid-transfer is harmless
  wire [31:0] rx_inc      = (rx_req.size == `SIZE_WORD) ? `STEP_WORD :
                            (rx_req.size == `SIZE_HALF) ? `STEP_HALF : `STEP_BYTE;
  wire [31:0] tx_inc      = (tx_req.size == `SIZE_WORD) ? `STEP_WORD :
                            (tx_req.size == `SIZE_HALF) ? `STEP_HALF : `STEP_BYTE;

  // request raised only while enabled and counter nonzero
  wire        rx_go       = rx_request_enable & (rx.count != `ZERO_COUNT) & rx_ready & ~rx_req.request;
  wire        tx_go       = tx_request_enable & (tx.count != `ZERO_COUNT) & tx_ready & ~tx_req.request;

  // control write decode; disable wins over enable on both channels
  wire        ctl_wr      = wr & hit_ctl;
  wire        rx_dis_wr   = ctl_wr & pwdata[`BIT_RX_DISABLE];
  wire        rx_en_wr    = ctl_wr & pwdata[`BIT_RX_ENABLE] & ~pwdata[`BIT_RX_DISABLE];
  wire        tx_dis_wr   = ctl_wr & pwdata[`BIT_TX_DISABLE];
  wire        tx_en_wr    = ctl_wr & pwdata[`BIT_TX_ENABLE] & ~pwdata[`BIT_TX_DISABLE];

  // channel advance after a completed transfer
  function automatic dma_pair_pkg::channel_state_type advance
  (
    input dma_pair_pkg::channel_state_type cur,
    input logic [31:0]                     inc
  );
    dma_pair_pkg::channel_state_type nxt;
    nxt = cur;
    nxt.pointer = cur.pointer + inc;
    nxt.count   = cur.count - `ONE_COUNT;
    // an empty next buffer leaves the pointer just past the last transfer
    if (nxt.count == `ZERO_COUNT && cur.next_count != `ZERO_COUNT)
    begin
      // chain into the next buffer
      nxt.pointer    = cur.next_pointer;
      nxt.count      = cur.next_count;
      nxt.next_count = `ZERO_COUNT;
    end
    return nxt;
  endfunction

  // software writes take effect after a transfer update in the same cycle
  function automatic dma_pair_pkg::channel_state_type sw_write
  (
    input dma_pair_pkg::channel_state_type cur,
    input logic                            wp,
    input logic                            wc,
    input logic                            wnp,
    input logic                            wnc,
    input logic [31:0]                     data,
    input logic [15:0]                     cdata
  );
    dma_pair_pkg::channel_state_type nxt;
    nxt = cur;
    if (wp)
      nxt.pointer = data;
    if (wc)
      nxt.count = cdata;
    if (wnp)
      nxt.next_pointer = data;
    if (wnc)
      nxt.next_count = cdata;
    return nxt;
  endfunction

  wire rx_step = rx_req.request & rx_done;
  wire tx_step = tx_req.request & tx_done;

  dma_pair_pkg::channel_state_type next_rx;
  dma_pair_pkg::channel_state_type next_tx;
  assign next_rx = sw_write(rx_step ? advance(rx, rx_inc) : rx, wr & hit_rp, wr & hit_rc, wr & hit_rnp,
                            wr & hit_rnc, pwdata, wcount);
  assign next_tx = sw_write(tx_step ? advance(tx, tx_inc) : tx, wr & hit_tp, wr & hit_tc, wr & hit_tnp,
                            wr & hit_tnc, pwdata, wcount);

  // counter reaching zero by transfer
  wire rx_hit_zero = rx_step & (rx.count == `ONE_COUNT);
  wire tx_hit_zero = tx_step & (tx.count == `ONE_COUNT);
  wire rx_cnt_wr   = wr & (hit_rc | hit_rnc);
  wire tx_cnt_wr   = wr & (hit_tc | hit_tnc);

  // flag levels; end set on reaching zero, cleared by counter writes
  wire next_rx_end  = rx_hit_zero | (rx_buffer_end_flag & ~rx_cnt_wr);
  wire next_tx_end  = tx_hit_zero | (tx_buffer_end_flag & ~tx_cnt_wr);
  wire next_rx_full = (next_rx.count == `ZERO_COUNT) & (next_rx.next_count == `ZERO_COUNT);
  wire next_tx_empty = (next_tx.count == `ZERO_COUNT) & (next_tx.next_count == `ZERO_COUNT);

  // sticky interrupt events; set wins over write-one-to-clear
  wire [`IRQ_BITS-1:0] irq_event;
  assign irq_event[`BIT_IRQ_RX_END]   = next_rx_end & ~rx_buffer_end_flag;
  assign irq_event[`BIT_IRQ_RX_FULL]  = next_rx_full & ~rx_buffers_full_flag;
  assign irq_event[`BIT_IRQ_TX_END]   = next_tx_end & ~tx_buffer_end_flag;
  assign irq_event[`BIT_IRQ_TX_EMPTY] = next_tx_empty & ~tx_buffers_empty_flag;
  wire [`IRQ_BITS-1:0] irq_clear  = (wr & hit_ist) ? pwdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
  wire [`IRQ_BITS-1:0] next_irq_status = irq_event | (irq_status & ~irq_clear);

  // read mux; unused bits read zero
  wire [31:0] status_word = {23'h000000, tx_request_enable, 7'h00, rx_request_enable};
  wire [31:0] read_word   = hit_rp  ? rx.pointer :
                            hit_rc  ? {16'h0000, rx.count} :
                            hit_tp  ? tx.pointer :
                            hit_tc  ? {16'h0000, tx.count} :
                            hit_rnp ? rx.next_pointer :
                            hit_rnc ? {16'h0000, rx.next_count} :
                            hit_tnp ? tx.next_pointer :
                            hit_tnc ? {16'h0000, tx.next_count} :
                            hit_sts ? status_word :
                            hit_ist ? {28'h0000000, irq_status} :
                            hit_imk ? {28'h0000000, irq_mask} : `ZERO_WORD;

  // request handshake: held until the bus side reports done
  wire next_rx_reqd = rx_go | (rx_req.request & ~rx_done);
  wire next_tx_reqd = tx_go | (tx_req.request & ~tx_done);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx <= '0;
      tx <= '0;
    end
    else
    begin
      rx <= next_rx;
      tx <= next_tx;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_request_enable <= 1'b0;
      tx_request_enable <= 1'b0;
    end
    else
    begin
      if (rx_dis_wr | rx_en_wr)
        rx_request_enable <= rx_en_wr;
      if (tx_dis_wr | tx_en_wr)
        tx_request_enable <= tx_en_wr;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_req                <= '0;
      tx_req                <= '0;
      rx_address            <= `ZERO_WORD;
      tx_address            <= `ZERO_WORD;
      rx_transfer_req       <= 1'b0;
      tx_transfer_req       <= 1'b0;
    end
    else
    begin
      rx_req.request        <= next_rx_reqd;
      tx_req.request        <= next_tx_reqd;
      if (rx_go)
        rx_req.size         <= transfer_size;
      if (tx_go)
        tx_req.size         <= transfer_size;
      if (rx_go)
        rx_address          <= rx.pointer;
      if (tx_go)
        tx_address          <= tx.pointer;
      rx_transfer_req       <= next_rx_reqd;
      tx_transfer_req       <= next_tx_reqd;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_buffer_end_flag    <= 1'b0;
      tx_buffer_end_flag    <= 1'b0;
      rx_buffers_full_flag  <= 1'b1;
      tx_buffers_empty_flag <= 1'b1;
      irq_status            <= {`IRQ_BITS{1'b0}};
      irq_mask              <= {`IRQ_BITS{1'b0}};
      irq                   <= 1'b0;
    end
    else
    begin
      rx_buffer_end_flag    <= next_rx_end;
      tx_buffer_end_flag    <= next_tx_end;
      rx_buffers_full_flag  <= next_rx_full;
      tx_buffers_empty_flag <= next_tx_empty;
      irq_status            <= next_irq_status;
      if (wr & hit_imk)
        irq_mask            <= pwdata[`IRQ_BITS-1:0];
      irq                   <= |(next_irq_status & ((wr & hit_imk) ? pwdata[`IRQ_BITS-1:0] : irq_mask));
    end
  end

  // read data registered in setup so the access phase answers at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= `ZERO_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= rd_phase ? read_word : `ZERO_WORD;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & bad_access;
    end
  end

endmodule

//--- verification/dma_pair_asserts.sv
`timescale 1ns/1ps
`include "dma_pair_defs.svh"
module dma_pair_asserts
(
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // channel side
  input wire logic        rx_done,
  input wire logic        tx_done,
  input wire logic        rx_transfer_req,
  input wire logic        tx_transfer_req,
  input wire logic [31:0] tx_address,
  input wire logic        rx_buffer_end_flag,
  input wire logic        tx_buffer_end_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  sequence s_wr(logic [11:0] a); acc && pwrite && paddr == a; endsequence
  // request may already have started at the write edge, so the window opens one cycle late
  property p_rx_off; s_wr(`OFS_CONTROL) ##0 pwdata[1] |=> ##1 (!$rose(rx_transfer_req)) [*3]; endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx request after disable");
  property p_tx_off; s_wr(`OFS_CONTROL) ##0 pwdata[9] |=> ##1 (!$rose(tx_transfer_req)) [*3]; endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx request after disable");
  property p_tx_clr; s_wr(`OFS_TX_NEXT_COUNTER) ##0 !tx_done |=> !tx_buffer_end_flag; endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx end flag kept after write");
  property p_rx_clr; s_wr(`OFS_RX_COUNTER) ##0 !rx_done |=> !rx_buffer_end_flag; endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx end flag kept after write");
  property p_tx_end; $rose(tx_buffer_end_flag) |-> $past(tx_done); endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx end flag without transfer");
  property p_tx_drop; tx_transfer_req && tx_done |=> !tx_transfer_req; endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("tx request held after done");
  property p_addr_hold; tx_transfer_req && $past(tx_transfer_req) |-> $stable(tx_address); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("tx address moved in transfer");
  property p_upper; acc && !pwrite && paddr[11:5] == 7'h08 && paddr[2] |-> prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("counter upper bits set");
endmodule

bind peripheral_dma_channel_pair dma_pair_asserts u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .rx_done(rx_done), .tx_done(tx_done),
  .rx_transfer_req(rx_transfer_req), .tx_transfer_req(tx_transfer_req), .tx_address(tx_address),
  .rx_buffer_end_flag(rx_buffer_end_flag), .tx_buffer_end_flag(tx_buffer_end_flag)
);

//--- verification/sysbus_model.sv
`timescale 1ns/1ps
module sysbus_model
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request and answer
  input  wire logic       req,
  input  wire logic [3:0] delay,
  output logic            done
);
  // delay per instance, so one channel sees a stalled bus
  logic [3:0] wait_count;
  wire        busy = req && !done;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      done       <= 1'b0;
      wait_count <= 4'h0;
    end
    else
    begin
      done       <= busy && wait_count == delay;
      wait_count <= (busy && wait_count != delay) ? wait_count + 4'h1 : 4'h0;
    end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
`include "dma_pair_defs.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rx_address, tx_address;
  logic        rx_ready, tx_ready, rx_done, tx_done, rx_transfer_req, tx_transfer_req, irq;
  logic        rx_buffer_end_flag, tx_buffer_end_flag, rx_buffers_full_flag, tx_buffers_empty_flag;
  logic [1:0]  transfer_size;
  logic [31:0] tx_log[$];
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  peripheral_dma_channel_pair u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_ready(rx_ready),
    .tx_ready(tx_ready), .transfer_size(transfer_size), .rx_done(rx_done), .tx_done(tx_done),
    .rx_transfer_req(rx_transfer_req), .tx_transfer_req(tx_transfer_req), .rx_address(rx_address),
    .tx_address(tx_address), .rx_buffer_end_flag(rx_buffer_end_flag), .tx_buffer_end_flag(tx_buffer_end_flag),
    .rx_buffers_full_flag(rx_buffers_full_flag), .tx_buffers_empty_flag(tx_buffers_empty_flag), .irq(irq)
  );
  sysbus_model u_tx_bus (.pclk(pclk), .presetn(presetn), .req(tx_transfer_req), .delay(4'h0), .done(tx_done));
  sysbus_model u_rx_bus (.pclk(pclk), .presetn(presetn), .req(rx_transfer_req), .delay(4'h3), .done(rx_done));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic end_sim;
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // completed transmit addresses, in order
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (tx_transfer_req && tx_done)
      tx_log.push_back(tx_address);
    if (cycles == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(n, r, e);
  endtask
  task automatic t_control;
    rd(`OFS_STATUS, 32'h0, "status reset");
    wr(`OFS_CONTROL, 32'h0000_0303);
    rd(`OFS_STATUS, 32'h0, "status both");
    wr(`OFS_CONTROL, 32'h0000_0101);
    rd(`OFS_STATUS, 32'h0000_0101, "status on");
    wr(`OFS_CONTROL, 32'h0);
    rd(`OFS_STATUS, 32'h0000_0101, "status zero write");
    wr(`OFS_CONTROL, 32'h0000_0202);
    rd(`OFS_STATUS, 32'h0, "status off");
  endtask
  task automatic t_regs;
    logic [31:0] d, r;
    logic [11:0] a;
    for (int k = 0; k < 6; k++)
    begin
      a = 12'h108 + 12'(4 * k);
      d = 32'hc3a5_5a00 + 32'(k);
      rd(a, 32'h0, "reset value");
      wr(a, d);
      rd(a, k[0] ? (d & 32'h0000_ffff) : d, "register");
      wr(a, 32'h0);
    end
    apb(1'b0, 12'h200, 32'h0, r);
    chk("unmapped", {r[30:0], last_err}, 32'h1);
    apb(1'b1, `OFS_STATUS, 32'hffff_ffff, r);
    rd(`OFS_STATUS, 32'h0, "status after write");
  endtask
  task automatic t_tx;
    wr(`OFS_TX_POINTER, 32'h0000_1000);
    wr(`OFS_TX_COUNTER, 32'h2);
    wr(`OFS_TX_NEXT_POINTER, 32'h0000_2000);
    wr(`OFS_TX_NEXT_COUNTER, 32'h1);
    transfer_size <= `SIZE_WORD;
    wr(`OFS_CONTROL, 32'h0000_0100);
    wait (tx_buffers_empty_flag === 1'b1);
    @(negedge pclk);
    chk("tx addresses", {tx_log[0][15:0], tx_log[1][15:0]}, 32'h1000_1004);
    chk("tx reload address", tx_log[2], 32'h0000_2000);
    chk("tx end flag", tx_buffer_end_flag, 32'h1);
    rd(`OFS_TX_POINTER, 32'h0000_2004, "tx pointer");
    rd(`OFS_TX_NEXT_COUNTER, 32'h0, "tx next count");
    chk("tx idle at zero", tx_transfer_req, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h4);
    repeat (2) @(negedge pclk);
    chk("irq raised", irq, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h4);
    repeat (2) @(negedge pclk);
    chk("irq cleared", irq, 32'h0);
    wr(`OFS_TX_NEXT_COUNTER, 32'h0);
    repeat (2) @(negedge pclk);
    chk("tx end cleared", tx_buffer_end_flag, 32'h0);
  endtask
  task automatic t_rx;
    wr(`OFS_RX_POINTER, 32'h0000_3000);
    wr(`OFS_RX_COUNTER, 32'h1);
    transfer_size <= `SIZE_HALF;
    wr(`OFS_CONTROL, 32'h0000_0001);
    wait (rx_buffer_end_flag === 1'b1);
    @(negedge pclk);
    chk("rx full flag", rx_buffers_full_flag, 32'h1);
    rd(`OFS_RX_POINTER, 32'h0000_3002, "rx pointer");
    wr(`OFS_RX_COUNTER, 32'h0);
    repeat (2) @(negedge pclk);
    chk("rx end cleared", rx_buffer_end_flag, 32'h0);
  endtask
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {rx_ready, tx_ready} = 2'h3;
    transfer_size = `SIZE_BYTE;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_control();
    t_regs();
    t_tx();
    t_rx();
    end_sim();
  end
endmodule
